/* File: shared/sld_pkg.sv */
// Constants for the squib loop low-level diagnostic control block.
// Assumes a 32-bit SPI frame: bit 31 write, bits 30:24 address, bits 19:0 data.
package sld_pkg;
  localparam int NCH = 4;
  localparam int NSLOT = 4;
  localparam int FRM_BITS = 32;
  localparam int FRM_WR = 31;
  localparam int FRM_AH = 30;
  localparam int FRM_AL = 24;
  localparam int DATA_W = 20;
  localparam logic [6:0] ADDR_STAT = 7'h37;
  localparam logic [6:0] ADDR_REQ = 7'h38;
  localparam logic [6:0] ADDR_ADC0 = 7'h3a;
  localparam logic [15:0] REQ_RST = 16'h0000;
  localparam int REQ_HL = 15;
  localparam int REQ_SOURCE_CURRENT = 14;
  localparam int REQ_PDALL = 13;
  localparam int REQ_SINK = 10;
  localparam logic [1:0] SRC_ON = 2'h1;
  localparam logic [1:0] SRC_BYP = 2'h2;
  localparam logic [1:0] MON_OFF = 2'h0;
  localparam logic [1:0] MON_HS = 2'h1;
  localparam logic [1:0] MON_LS = 2'h2;
  localparam logic [1:0] MON_LS_PD = 2'h3;
  localparam int ST_SBL = 7;
  localparam int ST_STG = 6;
  localparam int ST_STB = 5;
  localparam int ST_PIN = 4;
  localparam int ADC_DONE = 19;
  localparam logic [7:0] CODE_HS_FIRST = 8'h46;
  localparam logic [7:0] CODE_HS_LAST = 8'h49;
  typedef enum logic {ADC_IDLE, ADC_BUSY} sld_adc_st_t;
endpackage : sld_pkg

/* File: logic/sld_diag_ctrl.sv */
// Squib loop low-level diagnostic control: SPI register slave, request decode
// onto the analog switch controls, short flags and high-side pin conversions.
// Assumes all inputs, SPI pins included, are synchronous to i_clk_sys.
`timescale 1ns/1ps
module sld_diag_ctrl #(
  parameter int NCH = sld_pkg::NCH
) (
  // Clock, reset and clock enable.
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // SPI port, mode 0, MSB first.
  input wire logic i_spi_sclk,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  // Device operating state.
  input wire logic i_init_state,
  // Pin current monitor comparators.
  input wire logic i_mon_sinking,
  input wire logic i_mon_sourcing,
  // Analog switch controls, one bit per channel, plus two shared selects.
  output logic [NCH-1:0] o_src_en,
  output logic [NCH-1:0] o_byp_en,
  output logic [NCH-1:0] o_sink_en,
  output logic [NCH-1:0] o_pd_en,
  output logic [NCH-1:0] o_mon_hs,
  output logic [NCH-1:0] o_mon_ls,
  output logic o_src_alt_sel,
  output logic o_high_level_sel,
  // Converter handshake.
  output logic o_adc_start,
  output logic [1:0] o_adc_ch,
  input wire logic i_adc_done,
  input wire logic [9:0] i_adc_data
);
  localparam int NS = sld_pkg::NSLOT;

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic sclk_q_r;
  logic cs_q_r;
  logic [31:0] rx_r;
  logic [31:0] tx_r;
  logic [5:0] cnt_r;
  logic [6:0] resp_addr_r;
  logic frame_ok;
  logic [6:0] f_addr;
  logic [19:0] wdata;
  logic wr_req;
  logic [19:0] rd_data;
  logic [15:0] req_r;
  logic hl;
  logic [1:0] mon;
  logic [1:0] src;
  logic mon_conn;
  logic [NCH-1:0] leak_oh;
  logic [NCH-1:0] res_oh;
  logic [NCH-1:0] pd_nxt;
  logic stg_r;
  logic stb_r;
  logic [19:0] stat_word;
  logic [6:0] code_r [NS];
  logic [9:0] res_r [NS];
  logic [NS-1:0] pend_r;
  logic [NS-1:0] done_r;
  logic [NS-1:0] stale_r;
  logic [NS-1:0] adc_hit;
  logic code_ok;
  logic [1:0] cur_r;
  logic [1:0] pick;
  logic [6:0] ch_diff;
  sld_pkg::sld_adc_st_t st_r;

  // Reset is applied asynchronously but is released through two flops.
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Frame is accepted only with exactly 32 clocks; anything else is dropped.
  assign frame_ok = !cs_q_r && i_spi_cs_n && (cnt_r == 6'(sld_pkg::FRM_BITS));
  assign f_addr = rx_r[sld_pkg::FRM_AH:sld_pkg::FRM_AL];
  assign wdata = rx_r[sld_pkg::DATA_W-1:0];
  assign wr_req = frame_ok && rx_r[sld_pkg::FRM_WR] && (f_addr == sld_pkg::ADDR_REQ);
  assign o_spi_miso = tx_r[31];
  assign o_spi_miso_oe = !i_spi_cs_n;

  // SPI shifter: sample on rising sclk, shift out on falling sclk.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_r <= 1'b0;
      cs_q_r <= 1'b1;
      rx_r <= 32'h0;
      tx_r <= 32'h0;
      cnt_r <= 6'h0;
    end else if (i_ce) begin
      sclk_q_r <= i_spi_sclk;
      cs_q_r <= i_spi_cs_n;
      if (cs_q_r && !i_spi_cs_n) begin
        cnt_r <= 6'h0;
        tx_r <= {resp_addr_r, 5'h0, rd_data};
      end else if (!i_spi_cs_n && i_spi_sclk && !sclk_q_r) begin
        rx_r <= {rx_r[30:0], i_spi_mosi};
        if (cnt_r != 6'h3f) begin
          cnt_r <= cnt_r + 6'h1;
        end
      end else if (!i_spi_cs_n && !i_spi_sclk && sclk_q_r) begin
        tx_r <= {tx_r[30:0], 1'b0};
      end
    end
  end

  // The answer to a frame is shifted out in the next frame.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      resp_addr_r <= 7'h0;
    end else if (i_ce && frame_ok) begin
      resp_addr_r <= f_addr;
    end
  end

  // Request word; refused while in init so switches cannot move early.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= sld_pkg::REQ_RST;
    end else if (i_ce && wr_req && !i_init_state) begin
      req_r <= wdata[15:0];
    end
  end

  assign hl = req_r[sld_pkg::REQ_HL];
  assign mon = req_r[9:8];
  assign src = req_r[12:11];
  assign mon_conn = !hl && (mon != sld_pkg::MON_OFF);

  // Decode the request onto per-channel switch controls.
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      leak_oh[i] = (req_r[3:0] == 4'(i));
      res_oh[i] = (req_r[7:4] == 4'(i));
      if (!hl && (mon == sld_pkg::MON_LS_PD) && leak_oh[i]) begin
        pd_nxt[i] = 1'b1;
      end else if (!hl && req_r[sld_pkg::REQ_PDALL]) begin
        pd_nxt[i] = 1'b0;
      end else if (mon_conn && leak_oh[i]) begin
        pd_nxt[i] = 1'b0;
      end else begin
        pd_nxt[i] = 1'b1;
      end
    end
  end

  // Switch controls are registered so the analog side never sees glitches.
  // High-level mode belongs to other logic, so source, sink and monitor switches open and every pull-down is on.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_src_en <= '0;
      o_byp_en <= '0;
      o_sink_en <= '0;
      o_pd_en <= '1;
      o_mon_hs <= '0;
      o_mon_ls <= '0;
      o_src_alt_sel <= 1'b0;
      o_high_level_sel <= 1'b0;
    end else if (i_ce) begin
      o_src_en <= (!hl && src == sld_pkg::SRC_ON) ? res_oh : '0;
      o_byp_en <= (!hl && src == sld_pkg::SRC_BYP) ? res_oh : '0;
      o_sink_en <= (!hl && req_r[sld_pkg::REQ_SINK]) ? res_oh : '0;
      o_pd_en <= pd_nxt;
      o_mon_hs <= (!hl && mon == sld_pkg::MON_HS) ? leak_oh : '0;
      o_mon_ls <= (!hl && mon[1]) ? leak_oh : '0;
      o_src_alt_sel <= req_r[sld_pkg::REQ_SOURCE_CURRENT];
      o_high_level_sel <= hl;
    end
  end

  // Short flags: cleared by a new request, set by the monitor; set wins.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stg_r <= 1'b0;
      stb_r <= 1'b0;
    end else if (i_ce) begin
      if (mon_conn && i_mon_sinking) begin
        stg_r <= 1'b1;
      end else if (wr_req && !i_init_state) begin
        stg_r <= 1'b0;
      end
      if (mon_conn && i_mon_sourcing) begin
        stb_r <= 1'b1;
      end else if (wr_req && !i_init_state) begin
        stb_r <= 1'b0;
      end
    end
  end

  // Status word, 20 bits; loop shorts are not detected here so bit 7 is 0.
  always_comb begin
    stat_word = 20'h0;
    stat_word[19] = hl;
    stat_word[11:8] = req_r[7:4];
    stat_word[3:0] = req_r[3:0];
    stat_word[sld_pkg::ST_SBL] = 1'b0;
    stat_word[sld_pkg::ST_STG] = stg_r;
    stat_word[sld_pkg::ST_STB] = stb_r;
    stat_word[sld_pkg::ST_PIN] = (mon == sld_pkg::MON_HS);
  end

  // Only high-side pin codes are convertible; others leave the slot alone.
  assign code_ok = (wdata[7:0] >= sld_pkg::CODE_HS_FIRST) &&
                   (wdata[7:0] <= sld_pkg::CODE_HS_LAST) && (wdata[19:8] == 12'h0);
  always_comb begin
    for (int k = 0; k < NS; k++) begin
      adc_hit[k] = frame_ok && rx_r[sld_pkg::FRM_WR] && code_ok &&
                   (f_addr == sld_pkg::ADDR_ADC0 + 7'(k));
    end
  end

  // Lowest pending slot is served first.
  always_comb begin
    pick = 2'h0;
    for (int k = NS - 1; k >= 0; k--) begin
      if (pend_r[k]) begin
        pick = 2'(k);
      end
    end
  end
  assign ch_diff = code_r[pick] - sld_pkg::CODE_HS_FIRST[6:0];

  // Slot storage. A slot rewritten mid-conversion is marked stale so the old
  // result is thrown away and the new request is converted afterwards.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r <= '0;
      done_r <= '0;
      stale_r <= '0;
      for (int k = 0; k < NS; k++) begin
        code_r[k] <= 7'h0;
        res_r[k] <= 10'h0;
      end
    end else if (i_ce) begin
      for (int k = 0; k < NS; k++) begin
        if (adc_hit[k]) begin
          code_r[k] <= wdata[6:0];
          pend_r[k] <= 1'b1;
          done_r[k] <= 1'b0;
          stale_r[k] <= (st_r == sld_pkg::ADC_BUSY) && (cur_r == 2'(k));
        end else if (st_r == sld_pkg::ADC_BUSY && i_adc_done && cur_r == 2'(k)) begin
          if (!stale_r[k]) begin
            res_r[k] <= i_adc_data;
            done_r[k] <= 1'b1;
            pend_r[k] <= 1'b0;
          end
          stale_r[k] <= 1'b0;
        end
      end
    end
  end

  // Converter sequencer: one conversion in flight at a time.
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= sld_pkg::ADC_IDLE;
      cur_r <= 2'h0;
      o_adc_start <= 1'b0;
      o_adc_ch <= 2'h0;
    end else if (i_ce) begin
      o_adc_start <= 1'b0;
      unique case (st_r)
        sld_pkg::ADC_IDLE: begin
          if (|pend_r) begin
            st_r <= sld_pkg::ADC_BUSY;
            cur_r <= pick;
            o_adc_start <= 1'b1;
            o_adc_ch <= ch_diff[1:0];
          end
        end
        sld_pkg::ADC_BUSY: begin
          if (i_adc_done) begin
            st_r <= sld_pkg::ADC_IDLE;
          end
        end
      endcase
    end
  end

  // Read mux; the write-only request register and holes read as zero.
  always_comb begin
    rd_data = 20'h0;
    if (resp_addr_r == sld_pkg::ADDR_STAT) begin
      rd_data = stat_word;
    end
    for (int k = 0; k < NS; k++) begin
      if (resp_addr_r == sld_pkg::ADDR_ADC0 + 7'(k)) begin
        rd_data = {done_r[k], 2'h0, code_r[k], res_r[k]};
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  a_req_init_block: assert property (
    (i_ce && wr_req && i_init_state) |=> $stable(req_r))
    else $error("request changed during init");
  a_stg_from_mon: assert property (
    $rose(stg_r) |-> $past(i_mon_sinking) && $past(mon_conn))
    else $error("ground flag without monitor current");
  a_stb_set_src: assert property (
    (i_ce && mon_conn && i_mon_sourcing) |=> stb_r)
    else $error("battery flag not set");
  a_pin_low_side: assert property (
    (mon[1] && !hl) |-> !stat_word[sld_pkg::ST_PIN] && !stat_word[sld_pkg::ST_SBL])
    else $error("status pin bit wrong on low side");
  a_pd_all_off: assert property (
    (i_ce && !hl && req_r[13] && mon != sld_pkg::MON_LS_PD) |=> (o_pd_en == '0))
    else $error("pull-down left on");
  a_pd_others_on: assert property (
    (i_ce && !hl && !req_r[13] && mon == sld_pkg::MON_HS) |=> (o_pd_en == ~$past(leak_oh)))
    else $error("pull-down pattern wrong");
  a_mon_ls_pd: assert property (
    (i_ce && !hl && mon == sld_pkg::MON_LS_PD) |=> ((o_pd_en & o_mon_ls) == $past(leak_oh)))
    else $error("pull-down not enabled with monitor");
  a_src_sink_off: assert property (
    (i_ce && (src == 2'h0 || src == 2'h3) && !req_r[10]) |=> (o_src_en == '0 && o_sink_en == '0))
    else $error("source or sink left on");
  a_adc_bad_code: assert property (
    (i_ce && frame_ok && rx_r[31] && f_addr == sld_pkg::ADDR_ADC0 && !code_ok)
      |=> $stable(code_r[0]) && $stable(pend_r[0]))
    else $error("refused code was taken");
  a_adc_done_set: assert property (
    (i_ce && st_r == sld_pkg::ADC_BUSY && i_adc_done && !stale_r[cur_r] && !adc_hit[cur_r])
      |=> done_r[$past(cur_r)] ##0 (res_r[$past(cur_r)] == $past(i_adc_data)))
    else $error("conversion result not stored");

  c_leak_hs: cover property (i_ce && mon == sld_pkg::MON_HS && stg_r);
  c_pd_check: cover property (i_ce && mon == sld_pkg::MON_LS_PD && stg_r);
  c_adc_round: cover property (o_adc_start ##[1:20] (st_r == sld_pkg::ADC_BUSY && i_adc_done));
  c_stale: cover property (|stale_r);
endmodule : sld_diag_ctrl

/* File: tb/sld_host_model.sv */
// Host controller model: drives 32-bit SPI frames, mode 0, MSB first.
// Assumes the device samples the SPI pins with the same system clock.
`timescale 1ns/1ps
module sld_host_model (
  // System clock.
  input wire logic i_clk_sys,
  // SPI pins.
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  // Idle bus: clock low and select high.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // Converts a high-side pin result to volts through the input divider.
  function automatic real pin_volts(input logic [9:0] code);
    return real'(code) * 2.5 / 1024.0 * 15.0;
  endfunction : pin_volts

  // One whole frame; the SPI clock stays high for three system clocks and low
  // for six, because the device needs at least one to see it.
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    int i;
    rx = 32'h0;
    @(posedge i_clk_sys);
    o_cs_n <= 1'b0;
    for (i = 31; i >= 0; i--) begin
      repeat (3) @(posedge i_clk_sys);
      o_mosi <= tx[i];
      repeat (3) @(posedge i_clk_sys);
      o_sclk <= 1'b1;
      rx[i] = i_miso;
      repeat (3) @(posedge i_clk_sys);
      o_sclk <= 1'b0;
    end
    repeat (3) @(posedge i_clk_sys);
    o_cs_n <= 1'b1;
    o_mosi <= ~tx[0]; // A released line must not keep showing the last bit.
    repeat (3) @(posedge i_clk_sys);
  endtask : xfer
endmodule : sld_host_model

/* File: tb/test_squib_leakage_diag_control.sv */
// Self-checking bench for the squib loop low-level diagnostic control block.
// Assumes the host model drives SPI and this bench stands in for the converter.
`timescale 1ns/1ps
module test_squib_leakage_diag_control;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic init = 1'b0;
  logic snk = 1'b0;
  logic srcg = 1'b0;
  logic adc_done = 1'b0;
  logic [9:0] adc_data = 10'h000;
  logic sclk, cs_n, mosi, miso, miso_oe, adc_start, alt, hl;
  logic [1:0] adc_ch, cur_ch;
  logic [3:0] src_en, byp_en, sink_en, pd_en, mon_hs, mon_ls;
  logic [9:0] res [4];
  logic [9:0] nd;
  int cnt = 0;
  int error_cnt = 0;
  int checked = 0;

  // System clock, 100 ns period.
  always #50 clk = ~clk;

  sld_diag_ctrl sld_diag_ctrl_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_spi_sclk(sclk), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(miso),
    .o_spi_miso_oe(miso_oe), .i_init_state(init), .i_mon_sinking(snk),
    .i_mon_sourcing(srcg), .o_src_en(src_en), .o_byp_en(byp_en), .o_sink_en(sink_en),
    .o_pd_en(pd_en), .o_mon_hs(mon_hs), .o_mon_ls(mon_ls), .o_src_alt_sel(alt),
    .o_high_level_sel(hl), .o_adc_start(adc_start), .o_adc_ch(adc_ch),
    .i_adc_done(adc_done), .i_adc_data(adc_data));

  sld_host_model sld_host_model_inst (.i_clk_sys(clk), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_mosi(mosi), .i_miso(miso));

  // Converter stand-in: answers each start after 1 to 4 cycles; the channel
  // sits in the top result bits so a wrong channel shows in the slot value.
  always @(posedge clk) begin
    adc_done <= 1'b0;
    if (adc_start === 1'b1) begin
      cur_ch <= adc_ch;
      cnt <= 1 + int'($urandom_range(3));
    end else if (cnt == 1) begin
      nd = {cur_ch, 8'($urandom)};
      adc_data <= nd;
      adc_done <= 1'b1;
      res[cur_ch] <= nd;
      cnt <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end

  task automatic conclude();
    $display("counts: %0d checked, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [3:0] onehot(input logic [3:0] s);
    return (s < 4'h4) ? (4'h1 << s[1:0]) : 4'h0;
  endfunction : onehot

  task automatic reg_wr(input logic [6:0] a, input logic [19:0] d);
    logic [31:0] rx;
    sld_host_model_inst.xfer({1'b1, a, 4'h0, d}, rx);
  endtask : reg_wr

  // The answer arrives in the following frame, so a read costs two frames.
  task automatic reg_rd(input logic [6:0] a, output logic [19:0] d);
    logic [31:0] rx;
    sld_host_model_inst.xfer({1'b0, a, 24'h0}, rx);
    sld_host_model_inst.xfer(32'h0, rx);
    chk(32'(rx[31:20]), 32'({a, 5'h0}));
    d = rx[19:0];
  endtask : reg_rd

  // Expected switch outputs worked out from a request word.
  task automatic check_sw(input logic [15:0] q);
    logic [3:0] r, l, pd, z;
    logic on;
    on = ~q[15];
    z = 4'h0;
    r = on ? onehot(q[7:4]) : z;
    l = on ? onehot(q[3:0]) : z;
    // Outside high-level mode, bit 13 set turns every pull-down off, except the leakage channel's in low-side pull-down monitor mode.
    if (!on) pd = 4'hf;
    else if (q[13]) pd = (q[9:8] == sld_pkg::MON_LS_PD) ? l : z;
    else pd = (q[9:8] == sld_pkg::MON_LS_PD || q[9:8] == sld_pkg::MON_OFF) ? 4'hf : ~l;
    chk(32'(src_en), 32'((q[12:11] == sld_pkg::SRC_ON) ? r : z));
    chk(32'(byp_en), 32'((q[12:11] == sld_pkg::SRC_BYP) ? r : z));
    chk(32'(sink_en), 32'(q[10] ? r : z));
    chk(32'(pd_en), 32'(pd));
    chk(32'(mon_hs), 32'((q[9:8] == sld_pkg::MON_HS) ? l : z));
    chk(32'(mon_ls), 32'(q[9] ? l : z));
    chk(32'({hl, alt}), 32'(q[15:14]));
  endtask : check_sw

  // Monitor inputs stay low across the write so a stale set cannot win the clear.
  task automatic apply(input logic [15:0] q, input logic s, input logic b);
    logic [19:0] d;
    logic lo;
    lo = ~q[15] & (q[9:8] != 2'h0);
    @(posedge clk);
    snk <= 1'b0;
    srcg <= 1'b0;
    reg_wr(sld_pkg::ADDR_REQ, {4'h0, q});
    snk <= s;
    srcg <= b;
    repeat (3) @(posedge clk);
    check_sw(q);
    reg_rd(sld_pkg::ADDR_STAT, d);
    chk(32'(d), 32'({q[15], 7'h0, q[7:4], 1'b0, lo & s, lo & b, q[9:8] == 2'h1,
      q[3:0]}));
  endtask : apply

  // Hang guard.
  initial begin
    #(90000 * 100);
    error_cnt++;
    $display("test watchdog expired");
    conclude();
  end

  // Main sequence.
  initial begin
    logic [19:0] d, d0;
    logic [7:0] codes [4];
    logic [17:0] tbl [11];
    int k, n, rot;
    void'($urandom(70));
    tbl = '{18'h00000, 18'h00112, 18'h20223, 18'h10130, 18'h20311, 18'h22100,
      18'h02c22, 18'h07433, 18'h01800, 18'h38000, 18'h32301};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'({pd_en, adc_start, miso_oe}), 32'h0000003c);
    $display("test reset done");
    for (k = 0; k < 11; k++) apply(tbl[k][15:0], tbl[k][17], tbl[k][16]);
    $display("test corner requests done");
    for (k = 0; k < 30; k++) apply(16'($urandom) & 16'h7f33, 1'($urandom), 1'($urandom));
    $display("test random requests done");
    apply(16'h0112, 1'b0, 1'b0);
    init <= 1'b1;
    reg_wr(sld_pkg::ADDR_REQ, 20'h02c33);
    init <= 1'b0;
    check_sw(16'h0112);
    reg_rd(sld_pkg::ADDR_STAT, d);
    chk(32'(d), 32'h00000112);
    $display("test init refusal done");
    // The low-side level is read through the high-side code with the squib fitted.
    rot = $urandom_range(3);
    for (k = 0; k < 4; k++) begin
      codes[k] = sld_pkg::CODE_HS_FIRST + 8'((k + rot) % 4);
      reg_wr(sld_pkg::ADDR_ADC0 + 7'(k), {12'h0, codes[k]});
    end
    for (k = 0; k < 4; k++) begin
      n = 0;
      d = 20'h0;
      while (d[19] !== 1'b1) begin
        if (n++ == 8) begin
          error_cnt++;
          conclude();
        end
        reg_rd(sld_pkg::ADDR_ADC0 + 7'(k), d);
      end
      chk(32'(d), 32'({3'h4, codes[k][6:0], res[2'(codes[k] - 8'h46)]}));
      if (k == 0) d0 = d;
    end
    // Refused codes go to the first slot so the guard on that slot is exercised.
    reg_wr(sld_pkg::ADDR_ADC0, 20'h00045);
    reg_wr(sld_pkg::ADDR_ADC0, 20'h0004a);
    reg_rd(sld_pkg::ADDR_ADC0, d);
    chk(32'(d), 32'(d0));
    $display("test conversions done, last %f V", sld_host_model_inst.pin_volts(d0[9:0]));
    reg_wr(sld_pkg::ADDR_STAT, 20'hfffff);
    reg_rd(sld_pkg::ADDR_STAT, d);
    chk(32'(d), 32'h00000112);
    reg_rd(sld_pkg::ADDR_REQ, d);
    chk(32'(d), 32'h0);
    reg_rd(7'h50, d);
    chk(32'(d), 32'h0);
    $display("test register map done");
    conclude();
  end
endmodule : test_squib_leakage_diag_control
